// ---- core/psr_top.sv ----
// serial-port register bank with pcm transmit slot placement
`timescale 1ns/100ps
`include "psr_cfg.svh"
// Function
// RULE1: calibrate only if enabled and line controls low
// RULE2: host clears calibration before raising line controls
// RULE3: host avoids calibration in linear mode
// RULE4: wideband select picks 8 or 16 kHz
// RULE5: rate enable uses same 8/16 kHz coding
// RULE6: host sets rate enable before wideband select
// RULE7: bit offset delays transmit 0 to 7 clocks
// RULE8: edge select chooses falling or rising launch
// RULE9: seven-bit slot number selects transmit slot
// RULE10: frame holds up to 128 eight-bit slots
// RULE11: write-only boost bit raises transmit level
// RULE12: first bit at eight times slot plus offset
module psr_top import psr_pkg::*; #(
    parameter int SAMPLE_W = 8
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    input wire logic pcm_clk_i,
    input wire logic pcm_fsync_i,
    output logic pcm_tx_o,
    output logic pcm_tx_oe_o,
    input wire logic [SAMPLE_W-1:0] tx_sample_i,
    input wire psr_line_ctl_t line_ctl_i,
    input wire logic [7:0] cal_result_i,
    input wire logic cal_result_valid_i,
    output logic cal_active_o,
    output logic rate_16k_o,
    output logic rate_enable_o,
    output logic tx_level_boost_o,
    output logic rx_path_on_o,
    output logic [1:0] rx_analog_gain_o
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: stage one is read only by stage two
    // every pin here is asynchronous to clock_i; two stages cost a few
    // cycles of latency but keep metastable values away from the logic
    logic [1:0] sclk_s_r, cs_s_r, mosi_s_r, pclk_s_r, fs_s_r;
    logic sclk_d_r, pclk_d_r;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_s_r <= 2'h0;
            cs_s_r <= 2'h3;
            mosi_s_r <= 2'h0;
            pclk_s_r <= 2'h0;
            fs_s_r <= 2'h0;
            sclk_d_r <= 1'b0;
            pclk_d_r <= 1'b0;
        end else begin
            sclk_s_r <= {sclk_s_r[0], spi_sclk_i};
            cs_s_r <= {cs_s_r[0], spi_cs_n_i};
            mosi_s_r <= {mosi_s_r[0], spi_mosi_i};
            pclk_s_r <= {pclk_s_r[0], pcm_clk_i};
            fs_s_r <= {fs_s_r[0], pcm_fsync_i};
            sclk_d_r <= sclk_s_r[1];
            pclk_d_r <= pclk_s_r[1];
        end
    end

    // edge strobes from stage two against a delayed copy; the copies
    // reset to the idle low level so no false edge follows reset
    logic sclk_rise, sclk_fall, pclk_rise, pclk_fall, cs_n;
    assign sclk_rise = sclk_s_r[1] & ~sclk_d_r;
    assign sclk_fall = ~sclk_s_r[1] & sclk_d_r;
    assign pclk_rise = pclk_s_r[1] & ~pclk_d_r;
    assign pclk_fall = ~pclk_s_r[1] & pclk_d_r;
    assign cs_n = cs_s_r[1];

    ////////////////////////////////////////////////////////////////////////
    // register fields
    // boost has no read path: it is write-only and reads back as zero
    logic wideband_r, rate_en_r, boost_r, rxpath_r, cal_en_r;
    logic [1:0] gain_r;
    logic [7:0] result_r;
    psr_tx_place_t place_r;

    ////////////////////////////////////////////////////////////////////////
    // spi slave: rw bit, 7-bit address, 8 data bits, msb first
    // sclk must stay high and low for more than one cycle each, or
    // the synchroniser misses an edge and the frame slips by a bit
    logic [4:0] bit_cnt_r;
    logic [7:0] in_sr_r;
    logic [7:0] out_sr_r;
    logic [`PSR_ADDR_W-1:0] addr_r;
    logic rd_r;
    logic wr_stb;
    logic [7:0] wr_data;
    logic [7:0] in_nxt;
    assign in_nxt = {in_sr_r[6:0], mosi_s_r[1]};
    assign wr_stb = ~cs_n & sclk_rise & ~rd_r
                    & (bit_cnt_r == 5'(`PSR_SPI_BITS - 1));
    assign wr_data = in_nxt;

    // read mux; write-only and unmapped bits read as zero
    function automatic logic [7:0] rd_mux(input logic [6:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            `PSR_OFS_WIDEBAND: d[`PSR_BIT_WIDEBAND] = wideband_r;
            `PSR_OFS_GAIN: d[1:0] = gain_r;
            `PSR_OFS_RXPATH: d[`PSR_BIT_RXPATH] = rxpath_r;
            `PSR_OFS_CAL: d[`PSR_BIT_CAL] = cal_en_r;
            `PSR_OFS_TXSLOT: d = {place_r.edge_rise, place_r.slot};
            `PSR_OFS_RATE: d = {rate_en_r, 4'h0, place_r.bit_ofs};
            `PSR_OFS_RESULT: d = result_r;
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    // read word for the addressed register, taken at the first read fall
    logic [7:0] rd_word;
    always_comb begin
        rd_word = rd_mux(addr_r);
    end

    // shifter and bit counter; a raised select aborts the transfer
    // back-to-back frames are fine: the counter wraps after sixteen bits
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt_r <= 5'h00;
            in_sr_r <= 8'h00;
            addr_r <= 7'h00;
            rd_r <= 1'b0;
        end else if (cs_n) begin
            bit_cnt_r <= 5'h00;
            rd_r <= 1'b0;
        end else if (sclk_rise) begin
            in_sr_r <= in_nxt;
            if (bit_cnt_r == 5'd7) begin
                rd_r <= in_nxt[7];
                addr_r <= in_nxt[6:0];
            end
            if (bit_cnt_r != 5'(`PSR_SPI_BITS - 1))
                bit_cnt_r <= bit_cnt_r + 5'h01;
            else
                bit_cnt_r <= 5'h00;
        end
    end

    // read data loads after the address byte, shifts on falling sclk
    // miso is undriven between frames, so the host sees its own pull
    // level there and never a stale data bit
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            out_sr_r <= 8'h00;
            spi_miso_o <= 1'b0;
            spi_miso_oe_o <= 1'b0;
        end else if (cs_n) begin
            spi_miso_oe_o <= 1'b0;
            spi_miso_o <= 1'b0;
        end else if (sclk_fall) begin
            if (bit_cnt_r == 5'd8 && rd_r) begin
                spi_miso_o <= rd_word[7];
                out_sr_r <= {rd_word[6:0], 1'b0};
                spi_miso_oe_o <= 1'b1;
            end else if (bit_cnt_r > 5'd8 && rd_r) begin
                spi_miso_o <= out_sr_r[7];
                out_sr_r <= {out_sr_r[6:0], 1'b0};
            end else begin
                spi_miso_oe_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host-written fields
    // only a complete frame writes: a select raised early clears the
    // bit counter, so no strobe fires and the old value stays
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wideband_r <= `PSR_RST_BIT;
            rate_en_r <= `PSR_RST_BIT;
            boost_r <= `PSR_RST_BIT;
            rxpath_r <= `PSR_RST_BIT;
            cal_en_r <= `PSR_RST_BIT; // [RULE1]
            gain_r <= `PSR_RST_GAIN;
            place_r <= {`PSR_RST_BIT, `PSR_RST_SLOT, `PSR_RST_OFS};
        end else if (wr_stb) begin
            unique case (addr_r)
                `PSR_OFS_WIDEBAND:
                    wideband_r <= wr_data[`PSR_BIT_WIDEBAND]; // [RULE4]
                `PSR_OFS_GAIN: begin
                    gain_r <= wr_data[1:0];
                    boost_r <= wr_data[`PSR_BIT_BOOST]; // [RULE11]
                end
                `PSR_OFS_RXPATH: rxpath_r <= wr_data[`PSR_BIT_RXPATH];
                `PSR_OFS_CAL: cal_en_r <= wr_data[`PSR_BIT_CAL];
                `PSR_OFS_TXSLOT: begin
                    place_r.edge_rise <= wr_data[`PSR_BIT_EDGE]; // [RULE8]
                    place_r.slot <= wr_data[6:0]; // [RULE9]
                end
                `PSR_OFS_RATE: begin
                    rate_en_r <= wr_data[`PSR_BIT_RATE]; // [RULE5]
                    place_r.bit_ofs <= wr_data[2:0]; // [RULE7]
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calibration gate and result; a measurement beats a host write
    // line controls are same-clock levels: the gate closes one cycle
    // after any of them rises, and later measurements are dropped
    logic cal_gate;
    assign cal_gate = cal_en_r & ~line_ctl_i.off_hook_control
                      & ~line_ctl_i.dc_loop_enable
                      & ~line_ctl_i.nominal_mode_enable; // [RULE1]
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            result_r <= `PSR_RST_RESULT;
        end else if (cal_result_valid_i && cal_active_o) begin
            result_r <= cal_result_i; // [RULE1]
        end else if (wr_stb && addr_r == `PSR_OFS_RESULT) begin
            result_r <= wr_data;
        end
    end

    // registered control outputs
    // rate bits only leave the block: one sample per frame is sent even
    // in wideband mode, the faster framing lives outside this block
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cal_active_o <= 1'b0;
            rate_16k_o <= 1'b0;
            rate_enable_o <= 1'b0;
            tx_level_boost_o <= 1'b0;
            rx_path_on_o <= 1'b0;
            rx_analog_gain_o <= 2'h0;
        end else begin
            cal_active_o <= cal_gate; // [RULE1]
            rate_16k_o <= wideband_r; // [RULE4]
            rate_enable_o <= rate_en_r; // [RULE5]
            tx_level_boost_o <= boost_r; // [RULE11]
            rx_path_on_o <= rxpath_r;
            rx_analog_gain_o <= gain_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // highway clock counter: a rising edge with sync high is clock 0;
    // it saturates so a missing sync never wraps into a false slot
    // sync is taken on the rising edge whatever the launch edge, and the
    // sample is captured there too, but a rising launch at slot 0 offset 0 sends its first bit from the previous word;
    // the widest start, slot 127 plus offset 7, fits the counter easily
    logic [`PSR_CNT_W-1:0] cnt_r, cnt_nxt, start_pos, pos;
    logic [SAMPLE_W-1:0] sample_r;
    logic [3:0] sent_r;
    logic launch;
    assign cnt_nxt = fs_s_r[1] ? '0 :
                     (&cnt_r ? cnt_r : cnt_r + 1'b1);
    assign start_pos = `PSR_CNT_W'(place_r.slot) * `PSR_CNT_W'(`PSR_SLOT_BITS)
                       + `PSR_CNT_W'(place_r.bit_ofs); // [RULE10] [RULE12]
    assign launch = place_r.edge_rise ? pclk_rise : pclk_fall; // [RULE8]
    assign pos = place_r.edge_rise ? cnt_nxt : cnt_r;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '1;
            sample_r <= '0;
        end else if (pclk_rise) begin
            cnt_r <= cnt_nxt;
            if (fs_s_r[1])
                sample_r <= tx_sample_i; // sample held for the whole frame
        end
    end

    // transmit shifter: eight bits from start_pos, msb first
    // falling launch compares the count already held, rising launch the
    // count being loaded, so both modes start on the same clock index;
    // the enable drops at the ninth launch edge and frees the highway
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pcm_tx_o <= 1'b0;
            pcm_tx_oe_o <= 1'b0;
            sent_r <= 4'h0;
        end else if (launch) begin
            if (pos == start_pos) begin
                pcm_tx_o <= sample_r[SAMPLE_W-1]; // [RULE12] [RULE7]
                pcm_tx_oe_o <= 1'b1;
                sent_r <= 4'h1;
            end else if (sent_r != 4'h0 && sent_r < 4'(`PSR_SLOT_BITS)) begin
                pcm_tx_o <= sample_r[SAMPLE_W-1-int'(sent_r)]; // [RULE9]
                sent_r <= sent_r + 4'h1;
            end else begin
                pcm_tx_o <= 1'b0;
                pcm_tx_oe_o <= 1'b0;
                sent_r <= 4'h0;
            end
        end
    end

endmodule

// ---- pkg/psr_cfg.svh ----
// register offsets, field positions, reset values and widths for psr
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH
`define PSR_ADDR_W 7
`define PSR_DATA_W 8
`define PSR_OFS_WIDEBAND 7'h13
`define PSR_OFS_GAIN 7'h14
`define PSR_OFS_RXPATH 7'h16
`define PSR_OFS_CAL 7'h17
`define PSR_OFS_TXSLOT 7'h20
`define PSR_OFS_RATE 7'h22
`define PSR_OFS_RESULT 7'h25
`define PSR_BIT_WIDEBAND 0
`define PSR_BIT_BOOST 7
`define PSR_BIT_RXPATH 6
`define PSR_BIT_CAL 5
`define PSR_BIT_EDGE 7
`define PSR_BIT_RATE 7
`define PSR_RST_BIT 1'b0
`define PSR_RST_GAIN 2'h0
`define PSR_RST_SLOT 7'h00
`define PSR_RST_OFS 3'h0
`define PSR_RST_RESULT 8'h00
`define PSR_SLOT_BITS 8
`define PSR_CNT_W 11
`define PSR_SPI_BITS 16
`endif

// ---- pkg/psr_pkg.sv ----
// types shared by the psr configuration block
package psr_pkg;
    typedef struct packed {
        logic edge_rise;
        logic [6:0] slot;
        logic [2:0] bit_ofs;
    } psr_tx_place_t;
    typedef struct packed {
        logic off_hook_control;
        logic dc_loop_enable;
        logic nominal_mode_enable;
    } psr_line_ctl_t;
endpackage

// ---- tb/psr_host.sv ----
// host model that programs the block over its serial port
`timescale 1ns/100ps
module psr_host (
    input wire logic clock_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    // idle: deselected, clock low
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // one frame, 8 clocks per phase so the synchroniser sees each edge
    task automatic xfer(input logic rd, input logic [6:0] adr,
            input logic [7:0] wd, output logic [7:0] rdat);
        logic [15:0] f;
        f = {rd, adr, wd};
        rdat = 8'h00;
        @(negedge clock_i) cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi_o = f[i];
            repeat (8) @(negedge clock_i);
            if (i < 8) rdat[i] = miso_i;
            sclk_o = 1'b1;
            repeat (8) @(negedge clock_i);
            sclk_o = 1'b0;
        end
        repeat (8) @(negedge clock_i);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // released line shows no stale bit
        repeat (8) @(negedge clock_i);
    endtask
endmodule

// ---- tb/psr_top_assertions.sv ----
// checker for the psr block, seen only through its ports
`timescale 1ns/100ps
module psr_chk import psr_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic spi_cs_n_i,
    input wire logic pcm_clk_i,
    input wire psr_line_ctl_t line_ctl_i,
    input wire logic cal_active_o,
    input wire logic rate_16k_o,
    input wire logic rate_enable_o,
    input wire logic tx_level_boost_o,
    input wire logic pcm_tx_o,
    input wire logic pcm_tx_oe_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    AST_CAL_BLOCK: assert property (
        line_ctl_i != 3'b000 |=> !cal_active_o)
        else $error("calibration active with a line control set");
    AST_CAL_HOLD: assert property (
        cal_active_o && line_ctl_i == 3'b000 && spi_cs_n_i |=> cal_active_o)
        else $error("calibration dropped without cause");
    AST_RST_VALS: assert property (
        $fell(rst_i) |-> !rate_16k_o && !rate_enable_o && !cal_active_o)
        else $error("field not at reset value");
    AST_CTRL_HOLD: assert property (
        spi_cs_n_i [*8] |=>
        $stable({rate_16k_o, rate_enable_o, tx_level_boost_o}))
        else $error("field changed while port idle");
    AST_OE_LEN: assert property (
        $rose(pcm_tx_oe_o) |=> pcm_tx_oe_o [*8])
        else $error("transmit enable too short");
    AST_OE_GAP: assert property (
        $fell(pcm_tx_oe_o) |=> !pcm_tx_oe_o [*8])
        else $error("transmit enable glitch");
    AST_BIT_HOLD: assert property (
        pcm_tx_oe_o && $changed(pcm_tx_o) |=> $stable(pcm_tx_o) [*8])
        else $error("transmit bit too short");
    AST_OE_PCLK: assert property (
        $rose(pcm_tx_oe_o) |-> $past(pcm_clk_i, 8) != pcm_clk_i)
        else $error("transmit start away from a highway edge");
endmodule
bind psr_top psr_chk u_chk (.clock_i(clock_i), .rst_i(rst_i),
    .spi_cs_n_i(spi_cs_n_i), .pcm_clk_i(pcm_clk_i),
    .line_ctl_i(line_ctl_i), .cal_active_o(cal_active_o),
    .rate_16k_o(rate_16k_o), .rate_enable_o(rate_enable_o),
    .tx_level_boost_o(tx_level_boost_o), .pcm_tx_o(pcm_tx_o),
    .pcm_tx_oe_o(pcm_tx_oe_o));

// ---- tb/test_psr_top.sv ----
// self-checking bench for the psr block
`timescale 1ns/100ps
module test_psr_top;
    import psr_pkg::*;
    logic clock_i = 1'b0, rst_i = 1'b1, pcm_clk = 1'b0, fsync = 1'b0;
    logic cal_v = 1'b0, sclk, cs_n, mosi, miso, miso_oe, tx, tx_oe;
    logic cal_act, r16, ren, bst, rxon;
    logic [1:0] gain;
    logic [7:0] smp = 8'h00, cal_r = 8'h00, rd;
    psr_line_ctl_t line = 3'b000;
    int miscompares = 0, n_compared = 0;
    ////////////////////////////////////////////////////////////////////////
    psr_host host (.clock_i(clock_i), .sclk_o(sclk), .cs_n_o(cs_n),
        .mosi_o(mosi), .miso_i(miso_oe ? miso : 1'b1));
    psr_top DUT (.clock_i(clock_i), .rst_i(rst_i), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .spi_miso_oe_o(miso_oe), .pcm_clk_i(pcm_clk),
        .pcm_fsync_i(fsync), .pcm_tx_o(tx), .pcm_tx_oe_o(tx_oe),
        .tx_sample_i(smp), .line_ctl_i(line), .cal_result_i(cal_r),
        .cal_result_valid_i(cal_v), .cal_active_o(cal_act),
        .rate_16k_o(r16), .rate_enable_o(ren), .tx_level_boost_o(bst),
        .rx_path_on_o(rxon), .rx_analog_gain_o(gain));
    // clock and hang guard sized for the longest slot frame
    initial forever #2 clock_i = ~clock_i;
    initial begin
        #400000;
        miscompares++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, rd);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        host.xfer(1'b1, a, 8'h00, rd);
        chk("read", e, rd);
    endtask
    function automatic logic [7:0] outs();
        return {1'b0, cal_act, r16, ren, bst, rxon, gain};
    endfunction
    // rate, gain, boost and path fields; boost never reads back
    task automatic t_regs();
        chk("reset", 8'h00, outs());
        wr(7'h22, 8'h80); // rate enable first
        chk("rate", 8'h10, outs());
        wr(7'h13, 8'h01); // wideband select second
        chk("wide", 8'h30, outs());
        wr(7'h14, 8'h83);
        wr(7'h16, 8'h40);
        chk("boost", 8'h3f, outs());
        rdc(7'h14, 8'h03);
        rdc(7'h13, 8'h01);
        rdc(7'h16, 8'h40);
        wr(7'h25, 8'h5a);
        rdc(7'h25, 8'h5a);
        rdc(7'h30, 8'h00);
    endtask
    // calibration follows the dc loop control; off-hook is driven only with calibration cleared; plain samples only
    task automatic t_cal();
        wr(7'h17, 8'h20);
        chk("cal_on", 8'h01, {7'h0, cal_act});
        rdc(7'h17, 8'h20);
        cal_r = 8'h3c;
        cal_v = 1'b1;
        @(negedge clock_i) cal_v = 1'b0;
        rdc(7'h25, 8'h3c);
        line = 3'b010;
        repeat (3) @(negedge clock_i);
        chk("cal_dc", 8'h00, {7'h0, cal_act});
        line = 3'b000;
        wr(7'h17, 8'h00); // cleared before off-hook
        line = 3'b100;
        cal_r = 8'h77;
        cal_v = 1'b1;
        @(negedge clock_i) cal_v = 1'b0;
        rdc(7'h25, 8'h3c);
        line = 3'b000;
    endtask
    // one frame; oe and bits judged late in every highway half period
    task automatic t_pcm(input logic e, input logic [6:0] s,
            input logic [2:0] o);
        int l, j;
        logic on;
        l = 8 * s + o;
        wr(7'h20, {e, s});
        wr(7'h22, {5'h10, o});
        rdc(7'h20, {e, s});
        rdc(7'h22, {5'h10, o});
        smp = 8'ha5 ^ {1'b0, s};
        fsync = 1'b1;
        for (int k = 0; k <= l + 9; k++) begin
            for (int h = 1; h >= 0; h--) begin
                @(negedge clock_i) pcm_clk = h[0];
                repeat (19) @(negedge clock_i);
                if (h == 0) fsync = 1'b0;
                j = k - l - ((h == 1 && !e) ? 1 : 0);
                on = j >= 0 && j < 8;
                chk("tx_oe", 8'(on), 8'(tx_oe));
                if (on) begin
                    chk("tx_bit", 8'(smp[7 - j]), 8'(tx));
                end
            end
        end
    endtask
    task automatic conclude();
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // reset, then each scenario in turn
    initial begin
        repeat (5) @(negedge clock_i);
        rst_i = 1'b0;
        repeat (3) @(negedge clock_i);
        t_regs();
        t_cal();
        t_pcm(1'b0, 7'd1, 3'd3);
        t_pcm(1'b1, 7'd2, 3'd7);
        t_pcm(1'b1, 7'd127, 3'd0);
        conclude();
    end
endmodule
